//--- common/oscsel_map.vh
`ifndef OSCSEL_MAP_VH
`define OSCSEL_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OSCSEL_CTRL_OFF 4'h0
`define OSCSEL_TRIM_OFF 4'h4
`define OSCSEL_STAT_OFF 4'h8
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define OSCSEL_CUR_LSB 12
`define OSCSEL_LOCK_BIT 5
`define OSCSEL_KEEPON_BIT 1
`define OSCSEL_SLEEP_BIT 0
// ----------------------------------------
// Group codes
// ----------------------------------------
`define OSCSEL_GRP_PLL 3'b111
`define OSCSEL_GRP_EXT 3'b011
`define OSCSEL_GRP_LOW_POWER_INTERNAL_RC 3'b010
`define OSCSEL_GRP_FRC 3'b001
`define OSCSEL_GRP_SEC 3'b000
// ----------------------------------------
// Primary choice codes
// ----------------------------------------
`define OSCSEL_PR_EXT_CLOCK_IO_MODE 5'b0_1100
`define OSCSEL_PR_XT 5'b0_0100
`define OSCSEL_PR_HS 5'b0_0010
`define OSCSEL_PR_EC 5'b0_1011
`define OSCSEL_PR_ERC 5'b0_1001
`define OSCSEL_PR_EXT_RC_IO_MODE 5'b0_1000
`define OSCSEL_PR_XTL 5'b0_0000
// ----------------------------------------
// Source codes reported in status
// ----------------------------------------
`define OSCSEL_SRC_NONE 3'h0
`define OSCSEL_SRC_XTAL 3'h1
`define OSCSEL_SRC_EXTCLK 3'h2
`define OSCSEL_SRC_FRC 3'h3
`define OSCSEL_SRC_XTAL2 3'h4
`define OSCSEL_SRC_XTAL3 3'h5
`define OSCSEL_SRC_EXTRC 3'h6
`define OSCSEL_SRC_LOW_POWER_INTERNAL_RC 3'h7
// ----------------------------------------
// Output pin functions
// ----------------------------------------
`define OSCSEL_PIN_DRIVE 2'h0
`define OSCSEL_PIN_CLKOUT 2'h1
`define OSCSEL_PIN_GPIO 2'h2
// ----------------------------------------
// Start-up timer
// ----------------------------------------
`define OSCSEL_OST_LAST 10'h3ff
`endif

//--- verilog/oscsel_top.v
`timescale 1ns/1ps
`include "oscsel_map.vh"
module oscsel_top (
  input wire aclk,
  input wire aresetn,
  input wire por_event,
  input wire bor_event,
  input wire sleep_wake,
  input wire [2:0] group_select_cfg,
  input wire [4:0] primary_choice_cfg,
  input wire pll_lock_in,
  input wire osc_tick,
  input wire [3:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [3:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  output reg [2:0] current_group,
  output reg [2:0] clk_source,
  output reg [4:0] pll_gain,
  output reg pll_enable,
  output reg [1:0] osc_out_pin_func,
  output reg osc_in_pin_gpio,
  output reg secondary_osc_on,
  output reg secondary_is_clock,
  output reg sys_clk_release,
  output reg [3:0] fast_rc_trim,
  output reg sleep_active
);

  // ----------------------------------------
  // Internal state
  // ----------------------------------------
  reg [4:0] primary_choice;
  reg secondary_keep_on;
  reg pll_lock;
  reg [9:0] startup_delay_counter;
  reg ost_run;
  reg [2:0] prev_group;
  reg [3:0] aw_addr_q;
  reg aw_held;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg w_held;
  wire reset_evt;
  wire restart;
  wire need_ost;
  wire wr_go;

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function is_crystal;
    input [2:0] grp;
    input [4:0] pr;
    begin
      is_crystal = 1'b0;
      if (grp == `OSCSEL_GRP_EXT) begin
        is_crystal = (pr == `OSCSEL_PR_XT) || (pr == `OSCSEL_PR_HS) ||
                     (pr == `OSCSEL_PR_XTL);
      end else if (grp == `OSCSEL_GRP_PLL) begin
        is_crystal = (pr[4:2] == 3'b001) || (pr[4:2] == 3'b100) ||
                     (pr[4:2] == 3'b101);
      end
    end
  endfunction

  function [1:0] pin_func;
    input [2:0] grp;
    input [4:0] pr;
    begin
      pin_func = `OSCSEL_PIN_GPIO;
      if (grp == `OSCSEL_GRP_EXT) begin
        if (pr == `OSCSEL_PR_EC || pr == `OSCSEL_PR_ERC) begin
          pin_func = `OSCSEL_PIN_CLKOUT;
        end else if (pr == `OSCSEL_PR_XT || pr == `OSCSEL_PR_HS || pr == `OSCSEL_PR_XTL) begin
          pin_func = `OSCSEL_PIN_DRIVE;
        end
      end else if (grp == `OSCSEL_GRP_PLL) begin
        if (is_crystal(grp, pr)) begin
          pin_func = `OSCSEL_PIN_DRIVE;
        end
      end else begin
        // Non-primary groups still follow the primary choice
        if (pr == `OSCSEL_PR_EC || pr == `OSCSEL_PR_ERC) begin
          pin_func = `OSCSEL_PIN_CLKOUT;
        end else if (is_crystal(`OSCSEL_GRP_EXT, pr)) begin
          pin_func = `OSCSEL_PIN_DRIVE;
        end
      end
    end
  endfunction

  localparam SEL_CTRL = 2'h0;
  localparam SEL_TRIM = 2'h1;
  localparam SEL_STAT = 2'h2;
  localparam SEL_NONE = 2'h3;

  function [1:0] reg_sel;
    input [3:0] addr;
    begin
      if (addr == `OSCSEL_CTRL_OFF) begin
        reg_sel = SEL_CTRL;
      end else if (addr == `OSCSEL_TRIM_OFF) begin
        reg_sel = SEL_TRIM;
      end else if (addr == `OSCSEL_STAT_OFF) begin
        reg_sel = SEL_STAT;
      end else begin
        reg_sel = SEL_NONE;
      end
    end
  endfunction

  assign reset_evt = por_event || bor_event;
  assign need_ost = is_crystal(current_group, primary_choice);
  assign restart = reset_evt || sleep_wake ||
                   (prev_group == `OSCSEL_GRP_SEC && current_group != `OSCSEL_GRP_SEC);

  // ----------------------------------------
  // Group and choice capture
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      current_group <= `OSCSEL_GRP_FRC;
      primary_choice <= 5'h00;
      prev_group <= `OSCSEL_GRP_FRC;
      pll_lock <= 1'b0;
    end else begin
      if (reset_evt) begin
        current_group <= group_select_cfg;
        primary_choice <= primary_choice_cfg;
      end
      prev_group <= current_group;
      pll_lock <= pll_lock_in;
    end
  end

  // ----------------------------------------
  // Source decode
  // ----------------------------------------
  always @* begin
    clk_source = `OSCSEL_SRC_NONE;
    pll_gain = 5'h01;
    pll_enable = 1'b0;
    case (current_group)
      `OSCSEL_GRP_PLL: begin
        pll_enable = 1'b1;
        case (primary_choice[1:0])
          2'b01: pll_gain = 5'h04;
          2'b10: pll_gain = 5'h08;
          2'b11: pll_gain = 5'h10;
          default: pll_gain = 5'h01;
        endcase
        case (primary_choice[4:2])
          3'b001: clk_source = `OSCSEL_SRC_XTAL;
          3'b011: clk_source = `OSCSEL_SRC_EXTCLK;
          3'b000: clk_source = `OSCSEL_SRC_FRC;
          3'b010: clk_source = `OSCSEL_SRC_FRC;
          3'b100: clk_source = `OSCSEL_SRC_XTAL2;
          3'b101: clk_source = `OSCSEL_SRC_XTAL3;
          default: clk_source = `OSCSEL_SRC_NONE;
        endcase
      end
      `OSCSEL_GRP_EXT: begin
        case (primary_choice)
          `OSCSEL_PR_EXT_CLOCK_IO_MODE: clk_source = `OSCSEL_SRC_EXTCLK;
          `OSCSEL_PR_EC: clk_source = `OSCSEL_SRC_EXTCLK;
          `OSCSEL_PR_XT: clk_source = `OSCSEL_SRC_XTAL;
          `OSCSEL_PR_HS: clk_source = `OSCSEL_SRC_XTAL;
          `OSCSEL_PR_XTL: clk_source = `OSCSEL_SRC_XTAL;
          `OSCSEL_PR_ERC: clk_source = `OSCSEL_SRC_EXTRC;
          `OSCSEL_PR_EXT_RC_IO_MODE: clk_source = `OSCSEL_SRC_EXTRC;
          default: clk_source = `OSCSEL_SRC_NONE;
        endcase
      end
      `OSCSEL_GRP_LOW_POWER_INTERNAL_RC: clk_source = `OSCSEL_SRC_LOW_POWER_INTERNAL_RC;
      `OSCSEL_GRP_FRC: clk_source = `OSCSEL_SRC_FRC;
      default: clk_source = `OSCSEL_SRC_NONE;
    endcase
  end

  // ----------------------------------------
  // Pin and secondary oscillator outputs
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_out_pin_func <= `OSCSEL_PIN_GPIO;
      osc_in_pin_gpio <= 1'b0;
      secondary_osc_on <= 1'b0;
      secondary_is_clock <= 1'b0;
    end else begin
      osc_out_pin_func <= pin_func(current_group, primary_choice);
      osc_in_pin_gpio <= 1'b0;
      secondary_osc_on <= secondary_keep_on ||
                          (current_group == `OSCSEL_GRP_SEC && !sleep_active);
      secondary_is_clock <= (current_group == `OSCSEL_GRP_SEC) && secondary_keep_on;
    end
  end

  // ----------------------------------------
  // Start-up timer
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      startup_delay_counter <= 10'h000;
      ost_run <= 1'b0;
      sys_clk_release <= 1'b0;
    end else if (restart) begin
      startup_delay_counter <= 10'h000;
      ost_run <= 1'b1;
      sys_clk_release <= 1'b0;
    end else if (ost_run) begin
      if (!need_ost) begin
        ost_run <= 1'b0;
        sys_clk_release <= 1'b1;
      end else if (osc_tick) begin
        if (startup_delay_counter == `OSCSEL_OST_LAST) begin
          ost_run <= 1'b0;
          sys_clk_release <= 1'b1;
        end else begin
          startup_delay_counter <= startup_delay_counter + 10'h001;
        end
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign arready = !rvalid;
  assign wr_go = aw_held && w_held && !bvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      secondary_keep_on <= 1'b0;
      sleep_active <= 1'b0;
      fast_rc_trim <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (sleep_wake) begin
        sleep_active <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= 2'b00;
        if (reg_sel(aw_addr_q) == SEL_CTRL) begin
          if (w_strb_q[0]) begin
            secondary_keep_on <= w_data_q[`OSCSEL_KEEPON_BIT];
            if (!sleep_wake) begin
              sleep_active <= w_data_q[`OSCSEL_SLEEP_BIT];
            end
          end
        end else if (reg_sel(aw_addr_q) == SEL_TRIM) begin
          if (w_strb_q[0]) begin
            fast_rc_trim <= w_data_q[3:0];
          end
        end else if (reg_sel(aw_addr_q) == SEL_STAT) begin
          bresp <= 2'b00;
        end else begin
          bresp <= 2'b10;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= 2'b00;
      rdata <= 32'h0000_0000;
      if (reg_sel(araddr) == SEL_CTRL) begin
        rdata[`OSCSEL_CUR_LSB+2:`OSCSEL_CUR_LSB] <= current_group;
        rdata[`OSCSEL_LOCK_BIT] <= pll_lock;
        rdata[`OSCSEL_KEEPON_BIT] <= secondary_keep_on;
        rdata[`OSCSEL_SLEEP_BIT] <= sleep_active;
      end else if (reg_sel(araddr) == SEL_TRIM) begin
        rdata[3:0] <= fast_rc_trim;
      end else if (reg_sel(araddr) == SEL_STAT) begin
        rdata[2:0] <= clk_source;
        rdata[8:4] <= pll_gain;
        rdata[10:9] <= osc_out_pin_func;
        rdata[11] <= sys_clk_release;
        rdata[12] <= secondary_is_clock;
        rdata[13] <= ost_run;
        rdata[25:16] <= startup_delay_counter;
        rdata[30:26] <= primary_choice;
      end else begin
        rresp <= 2'b10;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

//--- dv/oscsel_monitor.sv
`timescale 1ns/1ps
`include "oscsel_map.vh"
module oscsel_monitor (
  input wire aclk,
  input wire aresetn,
  input wire por_event,
  input wire bor_event,
  input wire sleep_wake,
  input wire osc_tick,
  input wire [2:0] group_select_cfg,
  input wire [2:0] current_group,
  input wire [2:0] clk_source,
  input wire [4:0] pll_gain,
  input wire pll_enable,
  input wire osc_in_pin_gpio,
  input wire secondary_osc_on,
  input wire secondary_is_clock,
  input wire sys_clk_release
);
  // ----------------------------------------
  // Tick count since restart
  // ----------------------------------------
  logic [10:0] tick_cnt;
  logic [2:0] last_group;
  wire restart = por_event | bor_event | sleep_wake |
    (last_group == 3'h0 && current_group != 3'h0);
  always @(posedge aclk)
    last_group <= current_group;
  wire xtal = clk_source == `OSCSEL_SRC_XTAL || clk_source == `OSCSEL_SRC_XTAL2
    || clk_source == `OSCSEL_SRC_XTAL3;
  always @(posedge aclk) begin
    if (!aresetn || restart)
      tick_cnt <= 11'h000;
    else if (osc_tick && tick_cnt != 11'h7ff)
      tick_cnt <= tick_cnt + 11'h001;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_group_load: assert property ((por_event || bor_event) |=>
    current_group == $past(group_select_cfg)) else $error("group not loaded");
  a_pll_on: assert property (pll_enable == (current_group == `OSCSEL_GRP_PLL))
    else $error("pll enable wrong");
  a_gain_one: assert property (!pll_enable |-> pll_gain == 5'h01)
    else $error("gain outside pll group");
  a_in_pin_io: assert property (osc_in_pin_gpio == 1'b0)
    else $error("input pin offered as io");
  a_frc_src: assert property (current_group == `OSCSEL_GRP_FRC |->
    clk_source == `OSCSEL_SRC_FRC) else $error("fast rc not selected");
  a_sec_clock: assert property (secondary_is_clock |-> secondary_osc_on &&
    (current_group == 3'h0 || $past(current_group) == 3'h0)) else $error("secondary clock");
  a_restart_gate: assert property (restart |=> !sys_clk_release)
    else $error("clock not gated on restart");
  a_count_full: assert property ($rose(sys_clk_release) && xtal |->
    tick_cnt == 11'h400) else $error("crystal released at wrong count");
  a_fast_release: assert property (restart ##1 !(xtal || restart) |=>
    sys_clk_release) else $error("non crystal not released");
endmodule
bind oscsel_top oscsel_monitor u_oscsel_monitor (.aclk, .aresetn, .por_event, .bor_event,
  .sleep_wake, .osc_tick, .group_select_cfg, .current_group, .clk_source, .pll_gain,
  .pll_enable, .osc_in_pin_gpio, .secondary_osc_on, .secondary_is_clock, .sys_clk_release);

//--- dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn, por_event, bor_event, sleep_wake, pll_lock_in, osc_tick;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [2:0] group_select_cfg, awprot, arprot, current_group, clk_source;
  logic [4:0] primary_choice_cfg, pll_gain;
  logic [3:0] awaddr, araddr, wstrb, fast_rc_trim;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, osc_out_pin_func;
  logic pll_enable, osc_in_pin_gpio, secondary_osc_on, secondary_is_clock;
  logic sys_clk_release, sleep_active;
  int err_count, num_checks;
  oscsel_top u_oscsel_top (.*);
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task print_verdict;
    if (err_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!ad || !wd) begin
      @(posedge aclk);
      ad = ad || awready;
      wd = wd || wready;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    while (!bvalid) @(posedge aclk);
    chk("bresp", er, bresp);
    bready <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    chk("rdata", ed, rdata);
    chk("rresp", er, rresp);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task ticks(input int n);
    repeat (n) begin
      osc_tick <= 1'b1;
      @(posedge aclk);
      osc_tick <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task wake;
    sleep_wake <= 1'b1;
    @(posedge aclk);
    sleep_wake <= 1'b0;
    @(posedge aclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task cfg(input logic [2:0] g, input logic [4:0] p, input logic [2:0] s, input logic [4:0] gn,
    input logic [1:0] f, input bit x, input bit b);
    group_select_cfg <= g;
    primary_choice_cfg <= p;
    bor_event <= b;
    por_event <= !b;
    @(posedge aclk);
    bor_event <= 1'b0;
    por_event <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("group", g, current_group);
    chk("src", s, clk_source);
    chk("gain", gn, pll_gain);
    chk("pll_en", g == 3'h7, pll_enable);
    chk("pin", f, osc_out_pin_func);
    chk("in_io", 0, osc_in_pin_gpio);
    chk("rel", !x, sys_clk_release);
    if (x) begin
      ticks(300);
      wake();
      ticks(1023);
      chk("rel_early", 0, sys_clk_release);
      ticks(1);
      chk("rel_done", 1, sys_clk_release);
    end
  endtask
  task t_reset;
    chk("rst_group", 3'h1, current_group);
    chk("rst_src", 3'h3, clk_source);
    chk("rst_rel", 0, sys_clk_release);
    rd(4'h0, 32'h0000_1000, 2'h0);
    rd(4'h4, 32'h0000_0000, 2'h0);
    rd(4'hc, 32'h0000_0000, 2'h2);
    wr(4'hc, 32'hffff_ffff, 2'h2);
  endtask
  task t_sec;
    wr(4'h0, 32'h0000_0002, 2'h0);
    chk("sec_clk", 1, secondary_is_clock);
    wr(4'h0, 32'h0000_0003, 2'h0);
    chk("sleep", 1, sleep_active);
    chk("sec_on", 1, secondary_osc_on);
    wake();
    chk("woke", 0, sleep_active);
    wr(4'h0, 32'h0000_0001, 2'h0);
    chk("sec_off", 0, secondary_osc_on);
    chk("sec_clk0", 0, secondary_is_clock);
    wake();
    pll_lock_in <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(4'h0, 32'h0000_0020, 2'h0);
    pll_lock_in <= 1'b0;
    wr(4'h0, 32'h0000_7020, 2'h0);
    rd(4'h0, 32'h0000_0000, 2'h0);
    wr(4'h8, 32'hffff_ffff, 2'h0);
    chk("src_ro", 3'h0, clk_source);
    rd(4'h8, 32'h1000_0810, 2'h0);
    wr(4'h4, 32'h0000_0008, 2'h0);
    chk("trim_lo", 4'h8, fast_rc_trim);
    rd(4'h4, 32'h0000_0008, 2'h0);
    chk("gain_trim", 5'h01, pll_gain);
    wr(4'h4, 32'h0000_0007, 2'h0);
    chk("trim_hi", 4'h7, fast_rc_trim);
  endtask
  task t_leave;
    group_select_cfg <= 3'h3;
    primary_choice_cfg <= 5'h04;
    por_event <= 1'b1;
    @(posedge aclk);
    por_event <= 1'b0;
    osc_tick <= 1'b1;
    @(posedge aclk);
    osc_tick <= 1'b0;
    @(posedge aclk);
    chk("leave_grp", 3'h3, current_group);
    ticks(1023);
    chk("rel_sec", 0, sys_clk_release);
    ticks(1);
    chk("rel_main", 1, sys_clk_release);
  endtask
  initial begin
    {aresetn, por_event, bor_event, sleep_wake, pll_lock_in, osc_tick} = 0;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, awprot, arprot} = 0;
    {group_select_cfg, primary_choice_cfg, wdata} = 0;
    wstrb = 4'hf;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    cfg(3'h3, 5'h0c, 3'h2, 5'h01, 2'h2, 0, 0);
    cfg(3'h3, 5'h04, 3'h1, 5'h01, 2'h0, 1, 0);
    cfg(3'h3, 5'h02, 3'h1, 5'h01, 2'h0, 1, 0);
    cfg(3'h3, 5'h0b, 3'h2, 5'h01, 2'h1, 0, 0);
    cfg(3'h3, 5'h09, 3'h6, 5'h01, 2'h1, 0, 0);
    cfg(3'h3, 5'h08, 3'h6, 5'h01, 2'h2, 0, 0);
    cfg(3'h3, 5'h00, 3'h1, 5'h01, 2'h0, 1, 0);
    cfg(3'h7, 5'h0d, 3'h2, 5'h04, 2'h2, 0, 1);
    cfg(3'h7, 5'h01, 3'h3, 5'h04, 2'h2, 0, 1);
    cfg(3'h7, 5'h0a, 3'h3, 5'h08, 2'h2, 0, 1);
    cfg(3'h7, 5'h03, 3'h3, 5'h10, 2'h2, 0, 1);
    cfg(3'h7, 5'h06, 3'h1, 5'h08, 2'h0, 1, 1);
    cfg(3'h7, 5'h13, 3'h4, 5'h10, 2'h0, 1, 1);
    cfg(3'h7, 5'h15, 3'h5, 5'h04, 2'h0, 1, 1);
    cfg(3'h1, 5'h0b, 3'h3, 5'h01, 2'h1, 0, 0);
    cfg(3'h2, 5'h0c, 3'h7, 5'h01, 2'h2, 0, 0);
    cfg(3'h0, 5'h04, 3'h0, 5'h01, 2'h0, 0, 0);
    t_sec();
    t_leave();
    print_verdict();
  end
  initial begin
    repeat (60000) @(posedge aclk);
    err_count++;
    print_verdict();
  end
endmodule
